// ===== src/hub_cfg_pkg.sv
// constants for the hub descriptor configuration bank
package hub_cfg_pkg;
    // configuration map offsets
    localparam logic [7:0] OFS_SP_POWER = 8'h0c;
    localparam logic [7:0] OFS_BP_POWER = 8'h0d;
    localparam logic [7:0] OFS_SP_CUR = 8'h0e;
    localparam logic [7:0] OFS_BP_CUR = 8'h0f;
    localparam logic [7:0] OFS_SETTLE = 8'h10;
    localparam logic [7:0] OFS_LANG_HI = 8'h11;
    localparam logic [7:0] OFS_LANG_LO = 8'h12;
    localparam logic [7:0] OFS_MAKER_LEN = 8'h13;
    localparam logic [7:0] OFS_ITEM_LEN = 8'h14;
    localparam logic [7:0] OFS_UNIT_LEN = 8'h15;
    localparam logic [7:0] OFS_TEXT_FIRST = 8'h16;
    localparam logic [7:0] OFS_TEXT_LAST = 8'h53;
    localparam logic [7:0] OFS_CFG_LAST = OFS_UNIT_LEN;
    // byte-register indices, offset minus OFS_SP_POWER
    localparam int CFG_COUNT = 10;
    localparam logic [3:0] IDX_SP_POWER = 4'h0;
    localparam logic [3:0] IDX_BP_POWER = 4'h1;
    localparam logic [3:0] IDX_SP_CUR = 4'h2;
    localparam logic [3:0] IDX_BP_CUR = 4'h3;
    localparam logic [3:0] IDX_SETTLE = 4'h4;
    localparam logic [3:0] IDX_LANG_HI = 4'h5;
    localparam logic [3:0] IDX_LANG_LO = 4'h6;
    localparam logic [3:0] IDX_MAKER_LEN = 4'h7;
    localparam logic [3:0] IDX_ITEM_LEN = 4'h8;
    localparam logic [3:0] IDX_UNIT_LEN = 4'h9;
    // reset values
    localparam logic [7:0] RST_CTRL_CURRENT = 8'h32;
    localparam logic [7:0] RST_PLAIN = 8'h00;
    // limits and units
    localparam logic [7:0] MAX_TEXT_CHARS = 8'h1f;
    localparam logic [7:0] CURRENT_LIMIT = 8'h32;
    localparam int UNIT_SHIFT = 1;
    localparam int TEXT_BYTES = 62;
    // settle step timing
    localparam int SETTLE_STEP_MS = 2;
    localparam int CLK_HZ = 100_000_000;
    localparam int SETTLE_STEP_CYCLES = SETTLE_STEP_MS * (CLK_HZ / 1000);
    // pin slots in the input synchroniser
    localparam int PIN_MODE = 0;
    localparam int PIN_STRINGS = 1;
    localparam int PIN_START = 2;
    localparam int PIN_COUNT = 3;
endpackage

// ===== src/maker_text_store.sv
// byte store of the utf-16le maker text
`timescale 1ns/1ns
`default_nettype none
module maker_text_store (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [5:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [5:0] rd_idx_i,
    output logic [7:0] rd_byte_o,
    input wire logic [4:0] char_idx_i,
    output logic [15:0] char_o
);
    logic [7:0] text_r [0:hub_cfg_pkg::TEXT_BYTES-1];
    logic [5:0] lo_idx;
    logic [5:0] hi_idx;

    // low byte at the even address, high byte right after it
    assign lo_idx = {char_idx_i, 1'b0};
    assign hi_idx = {char_idx_i, 1'b1};
    // index 31 and offsets past the store would land outside the array, so they read as zero
    assign char_o = (hi_idx < 6'(hub_cfg_pkg::TEXT_BYTES)) ? {text_r[hi_idx], text_r[lo_idx]}
                                                           : {2{hub_cfg_pkg::RST_PLAIN}};
    assign rd_byte_o = (rd_idx_i < 6'(hub_cfg_pkg::TEXT_BYTES)) ? text_r[rd_idx_i] : hub_cfg_pkg::RST_PLAIN;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < hub_cfg_pkg::TEXT_BYTES; i++) begin
                text_r[i] <= hub_cfg_pkg::RST_PLAIN;
            end
        end else if (wr_en_i) begin
            text_r[wr_idx_i] <= wr_data_i;
        end
    end
endmodule
`default_nettype wire

// ===== src/hub_descriptor_config_bank.sv
// configuration register bank feeding the hub's usb descriptors
`timescale 1ns/1ns
`default_nettype none
module hub_descriptor_config_bank #(
    parameter int unsigned STEP_CYCLES = hub_cfg_pkg::SETTLE_STEP_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [7:0] cfg_wdata_i,
    input wire logic self_powered_i,
    input wire logic string_support_i,
    input wire logic port_power_start_i,
    input wire logic [4:0] text_char_idx_i,
    output logic [7:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    output logic [7:0] desc_max_power_o,
    output logic [8:0] desc_max_power_ma_o,
    output logic [7:0] desc_ctrl_current_o,
    output logic [8:0] desc_ctrl_current_ma_o,
    output logic [7:0] peripheral_current_o,
    output logic [15:0] language_id_o,
    output logic [7:0] maker_len_o,
    output logic [7:0] item_len_o,
    output logic [7:0] unit_len_o,
    output logic length_over_o,
    output logic current_over_o,
    output logic [15:0] text_char_o,
    output logic settle_busy_o,
    output logic port_power_good_o
);
    localparam int PW = $clog2(STEP_CYCLES + 1);
    localparam logic [PW-1:0] STEP_LAST = PW'(STEP_CYCLES - 1);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_GOOD = 3'b100
    } settle_e;

    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [7:0] clamp_len(input logic [7:0] len, input logic on);
        if (!on) begin
            clamp_len = hub_cfg_pkg::RST_PLAIN;
        end else if (len > hub_cfg_pkg::MAX_TEXT_CHARS) begin
            clamp_len = hub_cfg_pkg::MAX_TEXT_CHARS;
        end else begin
            clamp_len = len;
        end
    endfunction

    logic [7:0] cfg_r [0:hub_cfg_pkg::CFG_COUNT-1];
    logic [hub_cfg_pkg::PIN_COUNT-1:0] pin_s1_r;
    logic [hub_cfg_pkg::PIN_COUNT-1:0] pin_s2_r;
    logic start_d_r;
    settle_e state_r;
    settle_e state_nxt;
    logic [7:0] steps_r;
    logic [7:0] steps_nxt;
    logic [PW-1:0] presc_r;
    logic [PW-1:0] presc_nxt;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic [7:0] max_power_r;
    logic [8:0] max_power_ma_r;
    logic [7:0] ctrl_cur_r;
    logic [8:0] ctrl_cur_ma_r;
    logic [7:0] periph_cur_r;
    logic [15:0] lang_r;
    logic [7:0] maker_len_r;
    logic [7:0] item_len_r;
    logic [7:0] unit_len_r;
    logic len_over_r;
    logic cur_over_r;
    logic [15:0] char_r;
    logic busy_r;
    logic good_r;

    wire mode_self = pin_s2_r[hub_cfg_pkg::PIN_MODE];
    wire strings_on = pin_s2_r[hub_cfg_pkg::PIN_STRINGS];
    wire start_rise = pin_s2_r[hub_cfg_pkg::PIN_START] && !start_d_r;
    wire hit_cfg = in_range(cfg_addr_i, hub_cfg_pkg::OFS_SP_POWER, hub_cfg_pkg::OFS_CFG_LAST);
    wire hit_text = in_range(cfg_addr_i, hub_cfg_pkg::OFS_TEXT_FIRST, hub_cfg_pkg::OFS_TEXT_LAST);
    wire [3:0] cfg_idx = 4'(cfg_addr_i - hub_cfg_pkg::OFS_SP_POWER);
    wire [5:0] text_idx = 6'(cfg_addr_i - hub_cfg_pkg::OFS_TEXT_FIRST);
    wire text_wr = cfg_wr_i && hit_text;
    wire [7:0] text_byte;
    wire [15:0] text_char;
    // unmapped offsets read as zero and swallow writes
    wire [7:0] rd_sel = hit_cfg ? cfg_r[cfg_idx] : (hit_text ? text_byte : 8'h00);

    // power mode picks which pair of figures the descriptors carry
    wire [7:0] power_sel = mode_self ? cfg_r[hub_cfg_pkg::IDX_SP_POWER]
                                     : cfg_r[hub_cfg_pkg::IDX_BP_POWER];
    wire [7:0] cur_sel = mode_self ? cfg_r[hub_cfg_pkg::IDX_SP_CUR]
                                   : cfg_r[hub_cfg_pkg::IDX_BP_CUR];
    wire [8:0] power_ma = 9'(power_sel) << hub_cfg_pkg::UNIT_SHIFT;
    wire [8:0] cur_ma = 9'(cur_sel) << hub_cfg_pkg::UNIT_SHIFT;
    wire [15:0] lang_sel = {cfg_r[hub_cfg_pkg::IDX_LANG_HI],
                            cfg_r[hub_cfg_pkg::IDX_LANG_LO]};
    wire over_any = (cfg_r[hub_cfg_pkg::IDX_MAKER_LEN] > hub_cfg_pkg::MAX_TEXT_CHARS)
                 || (cfg_r[hub_cfg_pkg::IDX_ITEM_LEN] > hub_cfg_pkg::MAX_TEXT_CHARS)
                 || (cfg_r[hub_cfg_pkg::IDX_UNIT_LEN] > hub_cfg_pkg::MAX_TEXT_CHARS);
    // software may still write a bad self-powered current, so it is flagged, not refused
    wire cur_bad = cfg_r[hub_cfg_pkg::IDX_SP_CUR] > hub_cfg_pkg::CURRENT_LIMIT;

    maker_text_store u_text (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(text_wr),
        .wr_idx_i(text_idx),
        .wr_data_i(cfg_wdata_i),
        .rd_idx_i(text_idx),
        .rd_byte_o(text_byte),
        .char_idx_i(text_char_idx_i),
        .char_o(text_char)
    );

    // pins pass two flops before anything looks at them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            start_d_r <= 1'b0;
        end else begin
            pin_s1_r <= {port_power_start_i, string_support_i, self_powered_i};
            pin_s2_r <= pin_s1_r;
            start_d_r <= pin_s2_r[hub_cfg_pkg::PIN_START];
        end
    end

    generate
        for (genvar g = 0; g < hub_cfg_pkg::CFG_COUNT; g++) begin : g_cfg
            localparam logic [7:0] RST_V = (g == hub_cfg_pkg::IDX_SP_CUR
                || g == hub_cfg_pkg::IDX_BP_CUR) ? hub_cfg_pkg::RST_CTRL_CURRENT
                                                 : hub_cfg_pkg::RST_PLAIN;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cfg_r[g] <= RST_V;
                end else if (cfg_wr_i && hit_cfg && cfg_idx == 4'(g)) begin
                    cfg_r[g] <= cfg_wdata_i;
                end
            end
        end
    endgenerate

    // settle timer: steps of STEP_CYCLES each
    always_comb begin
        state_nxt = state_r;
        steps_nxt = steps_r;
        presc_nxt = presc_r;
        case (state_r)
            ST_IDLE, ST_GOOD: begin
                if (start_rise) begin
                    steps_nxt = cfg_r[hub_cfg_pkg::IDX_SETTLE];
                    presc_nxt = STEP_LAST;
                    state_nxt = (cfg_r[hub_cfg_pkg::IDX_SETTLE] == 8'h00) ? ST_GOOD : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (presc_r != '0) begin
                    presc_nxt = presc_r - PW'(1);
                end else if (steps_r == 8'h01) begin
                    state_nxt = ST_GOOD;
                end else begin
                    steps_nxt = steps_r - 8'h01;
                    presc_nxt = STEP_LAST;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            steps_r <= 8'h00;
            presc_r <= '0;
            busy_r <= 1'b0;
            good_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            steps_r <= steps_nxt;
            presc_r <= presc_nxt;
            busy_r <= state_nxt == ST_WAIT;
            good_r <= state_nxt == ST_GOOD;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            max_power_r <= 8'h00;
            max_power_ma_r <= 9'h000;
            ctrl_cur_r <= 8'h00;
            ctrl_cur_ma_r <= 9'h000;
            periph_cur_r <= 8'h00;
            lang_r <= 16'h0000;
            maker_len_r <= 8'h00;
            item_len_r <= 8'h00;
            unit_len_r <= 8'h00;
            len_over_r <= 1'b0;
            cur_over_r <= 1'b0;
            char_r <= 16'h0000;
        end else begin
            rdata_r <= cfg_rd_i ? rd_sel : 8'h00;
            rvalid_r <= cfg_rd_i;
            max_power_r <= power_sel;
            max_power_ma_r <= power_ma;
            ctrl_cur_r <= cur_sel;
            ctrl_cur_ma_r <= cur_ma;
            // compound peripheral always reports no draw of its own
            periph_cur_r <= 8'h00;
            lang_r <= lang_sel;
            maker_len_r <= clamp_len(cfg_r[hub_cfg_pkg::IDX_MAKER_LEN], strings_on);
            item_len_r <= clamp_len(cfg_r[hub_cfg_pkg::IDX_ITEM_LEN], strings_on);
            unit_len_r <= clamp_len(cfg_r[hub_cfg_pkg::IDX_UNIT_LEN], strings_on);
            len_over_r <= strings_on && over_any;
            cur_over_r <= cur_bad;
            char_r <= text_char;
        end
    end

    assign cfg_rdata_o = rdata_r;
    assign cfg_rvalid_o = rvalid_r;
    assign desc_max_power_o = max_power_r;
    assign desc_max_power_ma_o = max_power_ma_r;
    assign desc_ctrl_current_o = ctrl_cur_r;
    assign desc_ctrl_current_ma_o = ctrl_cur_ma_r;
    assign peripheral_current_o = periph_cur_r;
    assign language_id_o = lang_r;
    assign maker_len_o = maker_len_r;
    assign item_len_o = item_len_r;
    assign unit_len_o = unit_len_r;
    assign length_over_o = len_over_r;
    assign current_over_o = cur_over_r;
    assign text_char_o = char_r;
    assign settle_busy_o = busy_r;
    assign port_power_good_o = good_r;

    // helper logic watched only by the checks below
    logic [31:0] wait_cnt_r;
    logic [7:0] loaded_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_cnt_r <= 32'h0;
            loaded_r <= 8'h00;
        end else if (start_rise && state_r != ST_WAIT) begin
            wait_cnt_r <= 32'h0;
            loaded_r <= cfg_r[hub_cfg_pkg::IDX_SETTLE];
        end else if (state_r == ST_WAIT) begin
            wait_cnt_r <= wait_cnt_r + 32'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_bus_power_pick: assert property (
        !mode_self |=> desc_max_power_o == $past(cfg_r[hub_cfg_pkg::IDX_BP_POWER])
                    && desc_max_power_ma_o == 9'($past(cfg_r[hub_cfg_pkg::IDX_BP_POWER])) * 9'd2)
        else $error("bus-powered max power not reported in 2 mA units");
    chk_self_power_pick: assert property (
        mode_self |=> desc_max_power_o == $past(cfg_r[hub_cfg_pkg::IDX_SP_POWER])
                   && desc_max_power_ma_o == 9'($past(cfg_r[hub_cfg_pkg::IDX_SP_POWER])) * 9'd2)
        else $error("self-powered max power not reported in 2 mA units");
    chk_peripheral_zero: assert property (
        peripheral_current_o == 8'h00)
        else $error("embedded peripheral current not zero");
    chk_self_current_ma: assert property (
        mode_self |=> desc_ctrl_current_ma_o == 9'($past(cfg_r[hub_cfg_pkg::IDX_SP_CUR])) * 9'd2)
        else $error("self-powered controller current scaled wrongly");
    chk_self_current_rst: assert property (
        $past(rst_i) |-> cfg_r[hub_cfg_pkg::IDX_SP_CUR] == 8'd50)
        else $error("self-powered controller current default not 50");
    chk_bus_current_def: assert property (
        $past(rst_i) ##1 !mode_self |=> desc_ctrl_current_ma_o == 9'd100
                                     || $past(cfg_wr_i, 2))
        else $error("bus-powered controller current default not 100 mA");
    chk_current_flag: assert property (
        cfg_wr_i && cfg_addr_i == hub_cfg_pkg::OFS_SP_CUR && cfg_wdata_i > 8'd50
        ##1 !cfg_wr_i |=> current_over_o)
        else $error("over-limit controller current not flagged");
    chk_settle_time: assert property (
        $rose(port_power_good_o) && $past(state_r == ST_WAIT)
        |-> wait_cnt_r == 32'(loaded_r) * 32'(STEP_CYCLES))
        else $error("port settle delay length wrong");
    chk_lang_upper: assert property (
        cfg_wr_i && cfg_addr_i == 8'h11 |-> ##2 language_id_o[15:8] == $past(cfg_wdata_i, 2))
        else $error("language code upper byte not from 11h");
    chk_lang_lower: assert property (
        cfg_wr_i && cfg_addr_i == 8'h12 |-> ##2 language_id_o[7:0] == $past(cfg_wdata_i, 2))
        else $error("language code lower byte not from 12h");
    chk_len_limit: assert property (
        maker_len_o <= 8'd31 && item_len_o <= 8'd31 && unit_len_o <= 8'd31)
        else $error("text length above 31 characters");
    chk_text_order: assert property (
        cfg_wr_i && cfg_addr_i == 8'h17 ##1 !cfg_wr_i && text_char_idx_i == 5'h00
        |=> text_char_o[15:8] == $past(cfg_wdata_i, 2))
        else $error("maker text high byte not at odd address");
    chk_text_window: assert property (
        cfg_rd_i && (cfg_addr_i < 8'h0c || cfg_addr_i > 8'h53) |=> cfg_rdata_o == 8'h00)
        else $error("read outside the map not zero");
    chk_mode_follow: assert property (
        $changed(mode_self) && $stable(cfg_r[hub_cfg_pkg::IDX_SP_CUR])
        && $stable(cfg_r[hub_cfg_pkg::IDX_BP_CUR])
        |=> desc_ctrl_current_o == (mode_self ? cfg_r[hub_cfg_pkg::IDX_SP_CUR]
                                              : cfg_r[hub_cfg_pkg::IDX_BP_CUR]))
        else $error("controller current did not follow power mode");

    cov_settle_done: cover property ($rose(port_power_good_o));
    cov_mode_switch: cover property ($rose(mode_self));
    cov_len_clamp: cover property (length_over_o);
    cov_text_read: cover property (cfg_rd_i && hit_text);
endmodule
`default_nettype wire

// ===== verification/cfg_master_model.sv
// behavioural configuration master that loads the bank byte by byte
`timescale 1ns/1ns
`default_nettype none
module cfg_master_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // released lines show the inverse, so a stale value cannot pass for a real one
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        v = rvalid_i;
        d = rdata_i;
    endtask
    // low byte at the lower offset, high byte right after
    task automatic put_char(input logic [4:0] i, input logic [15:0] ch);
        put(8'h16 + {2'h0, i, 1'b0}, ch[7:0]);
        put(8'h17 + {2'h0, i, 1'b0}, ch[15:8]);
    endtask
    // put_current never loads controller current above the 100 mA limit
    task automatic put_current(input logic [7:0] a, input logic [7:0] d);
        put(a, (d > hub_cfg_pkg::CURRENT_LIMIT) ? hub_cfg_pkg::CURRENT_LIMIT : d);
    endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the hub descriptor configuration bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int STEP = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic self_powered = 1'b0;
    logic strings_on = 1'b1;
    logic start = 1'b0;
    logic [4:0] char_idx = 5'h00;
    logic cfg_wr, cfg_rd, cfg_rvalid, length_over, current_over, busy, good;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, max_power, ctrl_cur, periph, mlen, ilen, ulen;
    logic [8:0] max_power_ma, ctrl_cur_ma;
    logic [15:0] lang, text_char;
    int fail_count = 0;
    int cmp_count = 0;

    always #5 clk_i = ~clk_i;

    cfg_master_model master_u (.clk_i(clk_i), .rdata_i(cfg_rdata), .rvalid_i(cfg_rvalid),
        .wr_o(cfg_wr), .rd_o(cfg_rd), .addr_o(cfg_addr), .wdata_o(cfg_wdata));

    hub_descriptor_config_bank #(.STEP_CYCLES(STEP)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
        .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata), .self_powered_i(self_powered),
        .string_support_i(strings_on), .port_power_start_i(start), .text_char_idx_i(char_idx),
        .cfg_rdata_o(cfg_rdata), .cfg_rvalid_o(cfg_rvalid), .desc_max_power_o(max_power),
        .desc_max_power_ma_o(max_power_ma), .desc_ctrl_current_o(ctrl_cur),
        .desc_ctrl_current_ma_o(ctrl_cur_ma), .peripheral_current_o(periph),
        .language_id_o(lang), .maker_len_o(mlen), .item_len_o(ilen), .unit_len_o(ulen),
        .length_over_o(length_over), .current_over_o(current_over), .text_char_o(text_char),
        .settle_busy_o(busy), .port_power_good_o(good));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        master_u.get(a, d, v);
        check(16'(v), 16'h0001);
        check(16'(d), 16'(exp));
    endtask

    // outputs are read at the edge, before that edge's updates land
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic done_test(input string name);
        $display("test %s done, mismatches so far %0d", name, fail_count);
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        close_out();
    end

    initial begin
        int n;
        logic [15:0] ch;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 12; a <= 21; a++) begin
            rd_chk(8'(a), (a == 14 || a == 15) ? 8'h32 : 8'h00);
        end
        done_test("reset values");

        master_u.put(8'h0c, 8'h20);
        master_u.put(8'h0d, 8'h41);
        master_u.put_current(8'h0e, 8'h10);
        master_u.put_current(8'h0f, 8'h18);
        wait_cycles(3);
        check(16'(max_power), 16'h0041);
        check(16'(max_power_ma), 16'h0082);
        check(16'(ctrl_cur), 16'h0018);
        check(16'(ctrl_cur_ma), 16'h0030);
        check(16'(periph), 16'h0000);
        self_powered <= 1'b1;
        wait_cycles(5);
        check(16'(max_power), 16'h0020);
        check(16'(max_power_ma), 16'h0040);
        check(16'(ctrl_cur), 16'h0010);
        check(16'(ctrl_cur_ma), 16'h0020);
        done_test("power mode selection");

        // model clamps a request above the limit; a raw write shows the flag
        master_u.put_current(8'h0e, 8'h60);
        rd_chk(8'h0e, 8'h32);
        check(16'(current_over), 16'h0000);
        master_u.put(8'h0e, 8'h33);
        wait_cycles(3);
        check(16'(current_over), 16'h0001);
        done_test("current limit");

        master_u.put(8'h11, 8'h04);
        master_u.put(8'h12, 8'h09);
        wait_cycles(3);
        check(lang, 16'h0409);
        done_test("language code");

        master_u.put(8'h13, 8'h1f);
        master_u.put(8'h14, 8'h20);
        master_u.put(8'h15, 8'h05);
        wait_cycles(3);
        check(16'(mlen), 16'h001f);
        check(16'(ilen), 16'h001f);
        check(16'(ulen), 16'h0005);
        check(16'(length_over), 16'h0001);
        strings_on <= 1'b0;
        wait_cycles(5);
        check(16'(mlen), 16'h0000);
        check(16'(length_over), 16'h0000);
        done_test("text lengths");

        for (int i = 0; i < 31; i++) begin
            master_u.put_char(5'(i), {8'(i) ^ 8'ha5, 8'(i) + 8'h30});
        end
        for (int i = 0; i < 31; i++) begin
            char_idx <= 5'(i);
            wait_cycles(2);
            ch = {8'(i) ^ 8'ha5, 8'(i) + 8'h30};
            check(text_char, ch);
        end
        rd_chk(8'h16, 8'h30);
        rd_chk(8'h53, 8'hbb);
        master_u.put(8'h54, 8'h77);
        rd_chk(8'h54, 8'h00);
        rd_chk(8'h0b, 8'h00);
        done_test("maker text");

        master_u.put(8'h10, 8'h02);
        wait_cycles(2);
        start <= 1'b1;
        for (int k = 0; k < 20 && busy !== 1'b1; k++) begin
            @(posedge clk_i);
        end
        n = 0;
        while (good !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        check(16'(n), 16'(2 * STEP));
        check(16'(busy), 16'h0000);
        start <= 1'b0;
        done_test("port power settle");

        // mid-run reset, then a zero-step start and a restart from the good state
        rst_i <= 1'b1;
        wait_cycles(2);
        check(16'(good), 16'h0000);
        rst_i <= 1'b0;
        rd_chk(8'h10, 8'h00);
        rd_chk(8'h0e, 8'h32);
        start <= 1'b1;
        wait_cycles(5);
        check(16'(good), 16'h0001);
        check(16'(busy), 16'h0000);
        start <= 1'b0;
        master_u.put(8'h10, 8'h01);
        wait_cycles(2);
        start <= 1'b1;
        wait_cycles(5);
        check(16'(busy), 16'h0001);
        check(16'(good), 16'h0000);
        wait_cycles(4);
        check(16'(good), 16'h0001);
        check(16'(busy), 16'h0000);
        start <= 1'b0;
        done_test("reset and restart");
        close_out();
    end
endmodule
`default_nettype wire
